// >>> verilog/slf_top.sv
`timescale 1ns/1ns
`default_nettype none
module slf_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// avalon-mm register slave, byte addressed
	input wire logic [slf_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// link receivers, index i is the link of register i
	input wire logic [slf_pkg::NUM_LINKS-1:0] lnk_valid,
	input wire slf_pkg::slf_token_type [slf_pkg::NUM_LINKS-1:0] lnk_tok,
	output logic [slf_pkg::NUM_LINKS-1:0] lnk_ready,
	// static traffic to local channel ends
	output logic ce_valid,
	output slf_pkg::slf_entry_type ce_entry,
	input wire logic ce_ready,
	// routed traffic handed on unchanged
	output logic rt_valid,
	output logic [slf_pkg::LINK_IDX_W-1:0] rt_link,
	output slf_pkg::slf_token_type rt_tok,
	input wire logic rt_ready
);
	localparam int EW = $bits(slf_pkg::slf_entry_type);

	slf_pkg::slf_top_state_type st;
	slf_pkg::slf_top_state_type nx;

	logic hit;
	logic [slf_pkg::LINK_IDX_W-1:0] widx;
	logic wr_go;
	logic rd_ack;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [EW-1:0] fifo_out_data;
	logic gnt_any;
	logic [slf_pkg::LINK_IDX_W-1:0] gnt_idx;
	logic arb_adv;
	logic drained;
	logic capture;

	function automatic logic [31:0] cfg_word(input slf_pkg::slf_cfg_type c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[slf_pkg::CFG_EN_BIT] = c.en;
		w[slf_pkg::CFG_PROC_BIT] = c.proc;
		w[slf_pkg::CFG_CHAN_MSB:slf_pkg::CFG_CHAN_LSB] = c.chan;
		// every other bit stays zero
		return w;
	endfunction

	// word aligned, inside the eight-register window
	assign hit = (avs_address[1:0] == 2'h0)
		&& (avs_address[slf_pkg::ADDR_W-1:2] >= slf_pkg::CFG_IDX_FIRST)
		&& (avs_address[slf_pkg::ADDR_W-1:2] <= slf_pkg::CFG_IDX_LAST);
	assign widx = avs_address[4:2];
	assign wr_go = avs_write && !st.waitreq && hit;
	assign rd_ack = avs_read && st.waitreq;
	assign fifo_in_valid = st.hold_full && st.hold_static;

	assign avs_readdata = st.rdata;
	assign avs_waitrequest = st.waitreq;
	assign lnk_ready = st.lnk_rdy;
	assign rt_valid = st.rt_valid;
	assign rt_link = st.rt_link;
	assign rt_tok = st.rt_tok;
	assign ce_entry = fifo_out_data;

	slf_rr_arb #(
		.N(slf_pkg::NUM_LINKS),
		.IW(slf_pkg::LINK_IDX_W)
	) u_arb (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.req(lnk_valid),
		.adv(arb_adv),
		.gnt_any(gnt_any),
		.gnt_idx(gnt_idx)
	);

	slf_fifo #(
		.WIDTH(EW),
		.DEPTH(slf_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_data(st.hold),
		.in_ready(fifo_in_ready),
		.out_valid(ce_valid),
		.out_data(fifo_out_data),
		.out_ready(ce_ready)
	);

	always_comb begin
		nx = st;
		arb_adv = 1'b0;
		drained = 1'b0;
		capture = 1'b0;

		// bus: one wait cycle, then the answer stands for the sampling edge
		if ((avs_read || avs_write) && st.waitreq) begin
			nx.waitreq = 1'b0;
			nx.rdata = slf_pkg::BUS_UNMAPPED_DATA;
			if (avs_read && hit) begin
				nx.rdata = cfg_word(st.cfg[widx]);
			end
		end else begin
			nx.waitreq = 1'b1;
		end
		if (wr_go) begin
			if (avs_byteenable[slf_pkg::CFG_EN_BYTE]) begin
				nx.cfg[widx].en = avs_writedata[slf_pkg::CFG_EN_BIT];
			end
			if (avs_byteenable[slf_pkg::CFG_PROC_BYTE]) begin
				nx.cfg[widx].proc = avs_writedata[slf_pkg::CFG_PROC_BIT];
			end
			if (avs_byteenable[slf_pkg::CFG_CHAN_BYTE]) begin
				nx.cfg[widx].chan = avs_writedata[slf_pkg::CFG_CHAN_MSB:slf_pkg::CFG_CHAN_LSB];
			end
		end

		// routed output register
		if (st.rt_valid && rt_ready) begin
			nx.rt_valid = 1'b0;
		end
		if (st.hold_full) begin
			if (st.hold_static) begin
				drained = fifo_in_ready;
			end else begin
				drained = !st.rt_valid || rt_ready;
				if (drained) begin
					nx.rt_valid = 1'b1;
					nx.rt_link = st.hold_link;
					nx.rt_tok = st.hold.tok;
				end
			end
		end
		if (drained) begin
			nx.hold_full = 1'b0;
		end

		case (st.pkt)
			slf_pkg::SLF_IDLE: begin
				if (gnt_any) begin
					arb_adv = 1'b1;
					nx.pkt = slf_pkg::SLF_FWD;
					nx.sel = gnt_idx;
					// mode and destination are fixed for the whole packet, so a
					// register write in mid-packet takes effect on the next one
					nx.pkt_static = st.cfg[gnt_idx].en;
					nx.dest_proc = st.cfg[gnt_idx].proc;
					nx.dest_chan = st.cfg[gnt_idx].chan;
				end
			end
			slf_pkg::SLF_FWD: begin
				capture = lnk_valid[st.sel] && st.lnk_rdy[st.sel];
				if (capture) begin
					nx.hold_full = 1'b1;
					nx.hold_static = st.pkt_static;
					nx.hold_link = st.sel;
					nx.hold.tok = lnk_tok[st.sel];
					// the header token is carried as data only, never decoded
					nx.hold.proc = st.dest_proc;
					nx.hold.chan = st.dest_chan;
					if (lnk_tok[st.sel].eop) begin
						nx.pkt = slf_pkg::SLF_IDLE;
					end
				end
			end
			default: begin
				nx.pkt = slf_pkg::SLF_IDLE;
			end
		endcase

		// ready is registered, so a taken token closes it for at least one cycle
		nx.lnk_rdy = '0;
		if (nx.pkt == slf_pkg::SLF_FWD && !nx.hold_full) begin
			nx.lnk_rdy[nx.sel] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.cfg <= {slf_pkg::NUM_LINKS{slf_pkg::CFG_RESET}};
			st.waitreq <= 1'b1;
			st.pkt <= slf_pkg::SLF_IDLE;
		end else begin
			st <= nx;
		end
	end

	property p_cfg_en_write;
		@(posedge core_clk) disable iff (!rst_n)
		(wr_go && avs_byteenable[3]) |=> (st.cfg[$past(widx)].en == $past(avs_writedata[31]));
	endproperty
	a_cfg_en_write: assert property (p_cfg_en_write)
		else $error("enable bit not stored");

	property p_static_dest;
		@(posedge core_clk) disable iff (!rst_n)
		(st.pkt == slf_pkg::SLF_IDLE && gnt_any && st.cfg[gnt_idx].en)
		|=> st.pkt_static && (st.dest_chan == $past(st.cfg[gnt_idx].chan));
	endproperty
	a_static_dest: assert property (p_static_dest)
		else $error("static packet not bound to configured channel end");

	property p_no_route_static;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(st.rt_valid) |-> $past(st.hold_full) && !$past(st.hold_static);
	endproperty
	a_no_route_static: assert property (p_no_route_static)
		else $error("static traffic reached the routed output");

	property p_proc_write;
		@(posedge core_clk) disable iff (!rst_n)
		(wr_go && avs_byteenable[1]) |=> (st.cfg[$past(widx)].proc == $past(avs_writedata[8]));
	endproperty
	a_proc_write: assert property (p_proc_write)
		else $error("processor select not stored");

	property p_chan_write;
		@(posedge core_clk) disable iff (!rst_n)
		(wr_go && avs_byteenable[0]) |=> (st.cfg[$past(widx)].chan == $past(avs_writedata[4:0]));
	endproperty
	a_chan_write: assert property (p_chan_write)
		else $error("channel end not stored");

	property p_read_map;
		@(posedge core_clk) disable iff (!rst_n)
		(rd_ack && hit) |=> !avs_waitrequest
			&& (avs_readdata[4:0] == $past(st.cfg[widx].chan))
			&& (avs_readdata[31] == $past(st.cfg[widx].en));
	endproperty
	a_read_map: assert property (p_read_map)
		else $error("read returned another link's register");

	property p_reserved_zero;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(avs_waitrequest) |-> (avs_readdata[30:9] == 22'h000000)
			&& (avs_readdata[7:5] == 3'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits read nonzero");

	property p_bus_answer;
		@(posedge core_clk) disable iff (!rst_n)
		((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer not one cycle after request");

	property p_bus_idle;
		@(posedge core_clk) disable iff (!rst_n)
		!(avs_read || avs_write) |=> avs_waitrequest;
	endproperty
	a_bus_idle: assert property (p_bus_idle)
		else $error("bus answered without a request");

	// a write outside the window must leave every link register alone
	property p_unmapped_write;
		@(posedge core_clk) disable iff (!rst_n)
		(avs_write && !avs_waitrequest && !hit) |=> $stable(st.cfg);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write)
		else $error("write outside the window changed a register");

	property p_take_closes;
		@(posedge core_clk) disable iff (!rst_n)
		|(lnk_valid & lnk_ready) |=> (lnk_ready == '0);
	endproperty
	a_take_closes: assert property (p_take_closes)
		else $error("link stayed ready after a token was taken");

	property p_one_ready;
		@(posedge core_clk) disable iff (!rst_n)
		$onehot0(lnk_ready);
	endproperty
	a_one_ready: assert property (p_one_ready)
		else $error("more than one link ready at once");

	property p_ce_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(ce_valid && !ce_ready)
		|=> ce_valid && $stable(ce_entry);
	endproperty
	a_ce_hold: assert property (p_ce_hold)
		else $error("static output changed while stalled");

	property p_rt_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(rt_valid && !rt_ready)
		|=> rt_valid && $stable(rt_tok) && $stable(rt_link);
	endproperty
	a_rt_hold: assert property (p_rt_hold)
		else $error("routed output changed while stalled");

endmodule
`default_nettype wire

// >>> verilog/slf_pkg.sv
`default_nettype none
package slf_pkg;

	// link count and buffering
	localparam int NUM_LINKS = 8;
	localparam int LINK_IDX_W = 3;
	localparam int FIFO_DEPTH = 16;

	// register indices; byte address is four times the index
	localparam logic [9:0] CFG_IDX_FIRST = 10'h0A0;
	localparam logic [9:0] CFG_IDX_LAST = 10'h0A7;
	localparam int ADDR_W = 12;

	// link order of the eight registers, in address order
	localparam logic [2:0] LINK_C_IDX = 3'h0;
	localparam logic [2:0] LINK_D_IDX = 3'h1;
	localparam logic [2:0] LINK_A_IDX = 3'h2;
	localparam logic [2:0] LINK_B_IDX = 3'h3;
	localparam logic [2:0] LINK_G_IDX = 3'h4;
	localparam logic [2:0] LINK_H_IDX = 3'h5;
	localparam logic [2:0] LINK_E_IDX = 3'h6;
	localparam logic [2:0] LINK_F_IDX = 3'h7;

	// field positions of a static configuration word
	localparam int CFG_EN_BIT = 31;
	localparam int CFG_PROC_BIT = 8;
	localparam int CFG_CHAN_MSB = 4;
	localparam int CFG_CHAN_LSB = 0;
	localparam int CFG_EN_BYTE = 3;
	localparam int CFG_PROC_BYTE = 1;
	localparam int CFG_CHAN_BYTE = 0;

	// bus answer for unmapped reads
	localparam logic [31:0] BUS_UNMAPPED_DATA = 32'h0000_0000;

	typedef struct packed {
		logic en;
		logic proc;
		logic [4:0] chan;
	} slf_cfg_type;

	localparam slf_cfg_type CFG_RESET = '{en: 1'b0, proc: 1'b0, chan: 5'h00};

	typedef struct packed {
		logic ctrl;
		logic [7:0] data;
		logic eop;
	} slf_token_type;

	typedef struct packed {
		logic proc;
		logic [4:0] chan;
		slf_token_type tok;
	} slf_entry_type;

	typedef enum logic [0:0] {
		SLF_IDLE = 1'b0,
		SLF_FWD = 1'b1
	} slf_pkt_state_type;

	typedef struct packed {
		slf_cfg_type [NUM_LINKS-1:0] cfg;
		logic waitreq;
		logic [31:0] rdata;
		slf_pkt_state_type pkt;
		logic [LINK_IDX_W-1:0] sel;
		logic pkt_static;
		logic dest_proc;
		logic [4:0] dest_chan;
		logic [NUM_LINKS-1:0] lnk_rdy;
		logic hold_full;
		logic hold_static;
		logic [LINK_IDX_W-1:0] hold_link;
		slf_entry_type hold;
		logic rt_valid;
		logic [LINK_IDX_W-1:0] rt_link;
		slf_token_type rt_tok;
	} slf_top_state_type;

endpackage
`default_nettype wire

// >>> verilog/slf_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module slf_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side, registered
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [PW:0] count;
		logic out_valid;
		logic [WIDTH-1:0] out_data;
	} slf_fifo_state_type;

	slf_fifo_state_type st;
	slf_fifo_state_type nx;
	logic push;
	logic pop;

	assign in_ready = (st.count != DEPTH[PW:0]);
	assign out_valid = st.out_valid;
	assign out_data = st.out_data;

	always_comb begin
		nx = st;
		push = in_valid && in_ready;
		// refill the output register whenever it is empty or being taken
		pop = (st.count != '0) && (!st.out_valid || out_ready);
		if (st.out_valid && out_ready) begin
			nx.out_valid = 1'b0;
		end
		if (pop) begin
			nx.out_valid = 1'b1;
			nx.out_data = st.mem[st.rptr];
			nx.rptr = st.rptr + 1'b1;
		end
		if (push) begin
			nx.mem[st.wptr] = in_data;
			nx.wptr = st.wptr + 1'b1;
		end
		nx.count = st.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	property p_fifo_no_overfill;
		@(posedge core_clk) disable iff (!rst_n)
		(st.count == DEPTH[PW:0]) |-> !push;
	endproperty
	a_fifo_no_overfill: assert property (p_fifo_no_overfill)
		else $error("fifo written while full");

	// pointers and count are kept apart, so they must agree modulo depth
	property p_fifo_count;
		@(posedge core_clk) disable iff (!rst_n)
		(st.wptr - st.rptr) == st.count[PW-1:0];
	endproperty
	a_fifo_count: assert property (p_fifo_count)
		else $error("fifo pointers disagree with count");

endmodule
`default_nettype wire

// >>> verilog/slf_rr_arb.sv
`timescale 1ns/1ns
`default_nettype none
module slf_rr_arb #(
	parameter int N = 8,
	parameter int IW = 3
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// requests and grant
	input wire logic [N-1:0] req,
	input wire logic adv,
	output logic gnt_any,
	output logic [IW-1:0] gnt_idx
);
	typedef struct packed {
		logic [IW-1:0] ptr;
	} slf_arb_state_type;

	slf_arb_state_type st;
	slf_arb_state_type nx;
	logic [IW-1:0] cand;

	// search from the pointer so that no link is starved by a busy neighbour
	always_comb begin
		cand = '0;
		gnt_any = 1'b0;
		gnt_idx = '0;
		for (int k = N - 1; k >= 0; k--) begin
			cand = st.ptr + k[IW-1:0];
			if (req[cand]) begin
				gnt_any = 1'b1;
				gnt_idx = cand;
			end
		end
		nx = st;
		if (adv && gnt_any) begin
			nx.ptr = gnt_idx + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

endmodule
`default_nettype wire

// >>> sim/slf_link_src.sv
`timescale 1ns/1ns
`default_nettype none
module slf_link_src (
	// clock
	input wire logic core_clk,
	// link receivers of the block
	output logic [7:0] lnk_valid,
	output slf_pkg::slf_token_type [7:0] lnk_tok,
	input wire logic [7:0] lnk_ready
);
	int sent;
	initial begin
		lnk_valid = '0;
		lnk_tok = '0;
		sent = 0;
	end
	task automatic send_pkt(input int ln, input int n, input logic [7:0] base);
		for (int k = 0; k < n; k++) begin
			lnk_valid[ln] <= 1'b1;
			lnk_tok[ln] <= '{ctrl: 1'b0, data: base + 8'(k), eop: (k == n - 1)};
			do @(posedge core_clk); while (lnk_ready[ln] !== 1'b1);
			sent++;
			lnk_valid[ln] <= 1'b0;
			// released lines show garbage so a stale token cannot pass
			lnk_tok[ln] <= ~lnk_tok[ln];
			@(posedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_static_link_forwarding.sv
`timescale 1ns/1ns
`default_nettype none
module tb_static_link_forwarding;
	logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, ce_valid, ce_ready;
	logic rt_valid, rt_ready;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic [7:0] lnk_valid, lnk_ready;
	logic [2:0] rt_link;
	slf_pkg::slf_token_type [7:0] lnk_tok;
	slf_pkg::slf_entry_type ce_entry, ce_q[$];
	slf_pkg::slf_token_type rt_tok, rt_q[$];
	logic [2:0] rl_q[$];
	int fail_count, total_checks;

	slf_top dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .lnk_valid(lnk_valid), .lnk_tok(lnk_tok),
		.lnk_ready(lnk_ready), .ce_valid(ce_valid), .ce_entry(ce_entry),
		.ce_ready(ce_ready), .rt_valid(rt_valid), .rt_link(rt_link), .rt_tok(rt_tok),
		.rt_ready(rt_ready));
	slf_link_src src (.core_clk(core_clk), .lnk_valid(lnk_valid), .lnk_tok(lnk_tok),
		.lnk_ready(lnk_ready));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (ce_valid === 1'b1 && ce_ready === 1'b1) ce_q.push_back(ce_entry);
		if (rt_valid === 1'b1 && rt_ready === 1'b1) begin
			rt_q.push_back(rt_tok);
			rl_q.push_back(rt_link);
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	function automatic logic [11:0] ra(input int i);
		return 12'h280 + 12'(4 * i);
	endfunction
	task automatic wait_q(input int want);
		for (int k = 0; k < 300 && ce_q.size() + rt_q.size() < want; k++) @(posedge core_clk);
	endtask

	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			bus(0, ra(i), 32'h0, 4'hF);
			check(rd, 32'h0000_0000);
		end
		bus(1, 12'h300, 32'hFFFF_FFFF, 4'hF);
		bus(0, 12'h300, 32'h0, 4'hF);
		check(rd, 32'h0000_0000);
		bus(0, 12'h281, 32'h0, 4'hF);
		check(rd, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_regs;
		for (int i = 0; i < 8; i++) begin
			bus(1, ra(i), 32'hFFFF_FFFF, 4'hF);
			bus(0, ra(i), 32'h0, 4'hF);
			check(rd, 32'h8000_011F);
			bus(1, ra(i), 32'h0000_0000, 4'h1);
			bus(0, ra(i), 32'h0, 4'hF);
			check(rd, 32'h8000_0100);
		end
		for (int i = 0; i < 8; i++) bus(1, ra(i), 32'h8000_0000 | (i % 2) << 8 | (i + 3), 4'hF);
		for (int i = 0; i < 8; i++) begin
			bus(0, ra(i), 32'h0, 4'hF);
			check(rd, 32'h8000_0000 | (i % 2) << 8 | (i + 3));
		end
		$display("test registers done");
	endtask
	task automatic t_static;
		for (int i = 0; i < 8; i++) begin
			// header byte names link 7 minus i, which must be ignored
			src.send_pkt(i, 2, 8'(7 - i));
			wait_q(2);
			check(32'(ce_q.size()), 2);
			check(32'(rt_q.size()), 0);
			for (int k = 0; k < 2 && ce_q.size() > 0; k++)
				check(32'(ce_q.pop_front()), 32'({1'(i % 2), 5'(i + 3), 1'b0, 8'(7 - i + k),
					1'(k)}));
		end
		$display("test static done");
	endtask
	task automatic t_routed;
		bus(1, ra(2), 32'h7FFF_FFFF, 4'hF);
		// sink held off so the routed output has to stand until taken
		rt_ready <= 1'b0;
		src.send_pkt(2, 2, 8'h10);
		repeat (4) @(posedge core_clk);
		check(32'(rt_valid), 32'h1);
		rt_ready <= 1'b1;
		wait_q(2);
		check(32'(ce_q.size()), 0);
		check(32'(rt_q.size()), 2);
		for (int k = 0; k < 2 && rt_q.size() > 0; k++) begin
			check(32'(rl_q.pop_front()), 32'h2);
			check(32'(rt_q.pop_front()), 32'({1'b0, 8'h10 + 8'(k), 1'(k)}));
		end
		$display("test routed done");
	endtask
	task automatic t_fill;
		int sent0;
		ce_ready <= 1'b0;
		sent0 = src.sent;
		fork
			src.send_pkt(0, 20, 8'h00);
		join_none
		repeat (150) @(posedge core_clk);
		check(32'(src.sent - sent0 >= 16 && src.sent - sent0 < 20), 32'h1);
		ce_ready <= 1'b1;
		wait fork;
		wait_q(20);
		check(32'(ce_q.size()), 32'd20);
		for (int k = 0; k < 20 && ce_q.size() > 0; k++)
			check(32'(ce_q.pop_front()), 32'({1'b0, 5'h03, 1'b0, 8'(k), 1'(k == 19)}));
		$display("test fill done");
	endtask
	task automatic t_rereset;
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			bus(0, ra(i), 32'h0, 4'hF);
			check(rd, 32'h0000_0000);
		end
		// link 0 was static before the reset; it must now route
		src.send_pkt(0, 1, 8'h55);
		wait_q(1);
		check(32'(rt_q.size()), 32'h1);
		check(32'(ce_q.size()), 32'h0);
		$display("test second reset done");
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		avs_byteenable = '0;
		ce_ready = 1'b1;
		rt_ready = 1'b1;
		fail_count = 0;
		total_checks = 0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_reset;
		t_regs;
		t_static;
		t_routed;
		t_fill;
		t_rereset;
		stop_test;
	end
	initial begin
		#400000;
		fail_count++;
		stop_test;
	end
endmodule
`default_nettype wire
